/* slc_cfg.svh */
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH

// Register addresses carried in the 24-bit address phase.
`define SLC_ADDR_NONVOL      24'h000002
`define SLC_ADDR_VOL         24'h070002

// Field positions, write mask and reset value of the latency configuration register.
`define SLC_LAT_MSB          7
`define SLC_LAT_LSB          4
`define SLC_QUAD_BIT         1
`define SLC_WRITE_MASK       8'hf2
`define SLC_REG_RESET        8'h00

// Command opcodes.
`define SLC_OP_WRITE_ANY     8'h71
`define SLC_OP_READ_CFG1     8'h35
`define SLC_OP_READ_ANY      8'h65
`define SLC_OP_MEM_READ      8'h0b
`define SLC_OP_QUAD_READ     8'h6b

// Phase lengths in SCK periods.
`define SLC_CMD_BITS         5'h08
`define SLC_ADDR_BITS        5'h18
`define SLC_DATA_BITS        5'h08

`endif

/* slc_pkg.sv */
package slc_pkg;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } slc_state_t;

    typedef enum logic [1:0] {
        SRC_CFG,
        SRC_ANY,
        SRC_MEM
    } slc_src_t;

endpackage

/* slc_sync.sv */
module slc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // Each bit passes two flip-flops; the first stage feeds only the second.
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        logic stage1_r;
        logic stage2_r;
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                stage1_r <= 1'b0;
                stage2_r <= 1'b0;
            end else begin
                stage1_r <= async_i[g];
                stage2_r <= stage1_r;
            end
        end
        assign sync_o[g] = stage2_r;
    end

endmodule // slc_sync

/* slc_spi_latency_cfg.sv */
`include "slc_cfg.svh"

module slc_spi_latency_cfg
    import slc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Serial link pins
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    // Memory array read port
    output logic      [23:0] mem_addr_o,
    input  wire logic [7:0]  mem_rdata_i,
    // Effective configuration
    output logic      [3:0]  read_latency_code_o,
    output logic             quad_en_o
);

    logic [3:0]  pins_s;
    logic        sck_d_r;
    slc_state_t  state_r;
    slc_src_t    src_r;
    logic [4:0]  cnt_r;
    logic [6:0]  sh_r;
    logic [23:0] addr_r;
    logic [7:0]  nv_r;
    logic [7:0]  vol_r;
    logic [7:0]  tx_r;
    logic [2:0]  bc_r;
    logic        quad_rd_r;
    logic        hw_rst_d_r;
    logic        hit_any_r;

    slc_sync #(.WIDTH(4)) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  ({sck_i, cs_n_i, io_i[0], io_i[3]}),
        .sync_o   (pins_s)
    );

    wire         sck_s     = pins_s[3];
    wire         cs_n_s    = pins_s[2];
    wire         din_s     = pins_s[1];
    wire         hw_rst_n_s = pins_s[0];
    wire         sck_rise  = sck_s & ~sck_d_r;
    wire         sck_fall  = ~sck_s & sck_d_r;
    wire [7:0]   byte_in   = {sh_r, din_s};
    wire [4:0]   cnt_inc   = cnt_r + 5'h01;
    wire [3:0]   lat_code  = vol_r[`SLC_LAT_MSB:`SLC_LAT_LSB];
    wire         quad_on   = vol_r[`SLC_QUAD_BIT];
    wire [7:0]   wr_val    = byte_in & `SLC_WRITE_MASK;
    wire [23:0]  addr_full = {addr_r[22:0], din_s};
    wire         hit_nv    = addr_r == `SLC_ADDR_NONVOL;
    wire         hit_vol   = addr_r == `SLC_ADDR_VOL;
    wire         hit_any   = (addr_full == `SLC_ADDR_NONVOL) |
                             (addr_full == `SLC_ADDR_VOL);
    // The last address bit completes the memory address.
    wire         addr_done = ~cs_n_s & sck_rise & (state_r == ST_ADDR) &
                             (cnt_inc == `SLC_ADDR_BITS);
    // Register reads always see the volatile copy.
    wire [7:0]   reg_rd    = vol_r;
    wire         first     = bc_r == 3'h0;
    wire [7:0]   src_byte  = (src_r == SRC_MEM) ? mem_rdata_i :
                             ((src_r == SRC_ANY) & ~hit_any_r) ? 8'h00 : reg_rd;
    wire [7:0]   out_byte  = first ? src_byte : tx_r;
    wire [2:0]   bc_last   = quad_rd_r ? 3'h1 : 3'h7;
    // Hardware reset pin acts only while it is not a data lane.
    wire         hw_rst_fe = ~hw_rst_n_s & hw_rst_d_r & cs_n_s & ~quad_on;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_d_r    <= 1'b0;
            hw_rst_d_r <= 1'b1;
        end else begin
            sck_d_r    <= sck_s;
            hw_rst_d_r <= hw_rst_n_s;
        end
    end

    // Register copies.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nv_r  <= `SLC_REG_RESET;
            vol_r <= `SLC_REG_RESET;
        end else if (hw_rst_fe) begin
            vol_r <= nv_r;
        end else if (!cs_n_s && sck_rise && state_r == ST_WDATA && cnt_inc == `SLC_DATA_BITS) begin
            if (hit_nv) begin
                nv_r  <= wr_val;
                vol_r <= wr_val;
            end else if (hit_vol) begin
                vol_r <= wr_val;
            end
        end
    end

    // Command sequencer on rising SCK edges.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r   <= ST_CMD;
            src_r     <= SRC_CFG;
            cnt_r     <= 5'h00;
            sh_r      <= 7'h00;
            addr_r    <= 24'h000000;
            quad_rd_r <= 1'b0;
            hit_any_r <= 1'b0;
        end else if (cs_n_s) begin
            state_r   <= ST_CMD;
            cnt_r     <= 5'h00;
            quad_rd_r <= 1'b0;
        end else if (sck_rise) begin
            sh_r  <= byte_in[6:0];
            cnt_r <= cnt_inc;
            unique case (state_r)
                ST_CMD: begin
                    if (cnt_inc == `SLC_CMD_BITS) begin
                        cnt_r <= 5'h00;
                        if (byte_in == `SLC_OP_WRITE_ANY) begin
                            state_r <= ST_ADDR;
                            src_r   <= SRC_CFG;
                        end else if (byte_in == `SLC_OP_READ_ANY) begin
                            state_r <= ST_ADDR;
                            src_r   <= SRC_ANY;
                        end else if (byte_in == `SLC_OP_READ_CFG1) begin
                            state_r <= ST_RDATA;
                            src_r   <= SRC_CFG;
                        end else if (byte_in == `SLC_OP_MEM_READ) begin
                            state_r <= ST_ADDR;
                            src_r   <= SRC_MEM;
                        end else if (byte_in == `SLC_OP_QUAD_READ && quad_on) begin
                            state_r   <= ST_ADDR;
                            src_r     <= SRC_MEM;
                            quad_rd_r <= 1'b1;
                        end else begin
                            state_r <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_r <= addr_full;
                    if (cnt_inc == `SLC_ADDR_BITS) begin
                        cnt_r     <= 5'h00;
                        hit_any_r <= hit_any;
                        if (src_r == SRC_MEM) begin
                            // Mode-byte clocks fall inside this count, not on top of it.
                            state_r <= (lat_code == 4'h0) ? ST_RDATA : ST_DUMMY;
                        end else begin
                            state_r <= (src_r == SRC_ANY) ? ST_RDATA : ST_WDATA;
                        end
                    end
                end
                ST_DUMMY: begin
                    // One count per full SCK period.
                    if (cnt_inc[3:0] == lat_code) begin
                        state_r <= ST_RDATA;
                    end
                end
                ST_WDATA: begin
                    if (cnt_inc == `SLC_DATA_BITS) begin
                        state_r <= ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    cnt_r <= 5'h00;
                end
                ST_IGNORE: begin
                    cnt_r <= 5'h00;
                end
            endcase
        end
    end

    // Output shifter on falling SCK edges.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_o       <= 4'h0;
            io_oe_o    <= 4'h0;
            tx_r       <= 8'h00;
            bc_r       <= 3'h0;
            mem_addr_o <= 24'h000000;
        end else if (cs_n_s || state_r != ST_RDATA) begin
            io_oe_o <= 4'h0;
            bc_r    <= 3'h0;
            if (addr_done) begin
                mem_addr_o <= addr_full;
            end
        end else if (sck_fall) begin
            bc_r <= (bc_r == bc_last) ? 3'h0 : bc_r + 3'h1;
            if (quad_rd_r) begin
                io_o    <= out_byte[7:4];
                io_oe_o <= 4'hf;
                tx_r    <= {out_byte[3:0], 4'h0};
            end else begin
                io_o    <= {2'b00, out_byte[7], 1'b0};
                io_oe_o <= 4'h2;
                tx_r    <= {out_byte[6:0], 1'b0};
            end
            if (first && src_r == SRC_MEM) begin
                mem_addr_o <= mem_addr_o + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_latency_code_o <= 4'h0;
            quad_en_o           <= 1'b0;
        end else begin
            read_latency_code_o <= lat_code;
            quad_en_o           <= quad_on;
        end
    end

endmodule // slc_spi_latency_cfg

/* slc_spi_latency_cfg_chk.sv */
module slc_spi_latency_cfg_chk (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    // Watched ports
    input wire logic       sck_i,
    input wire logic       cs_n_i,
    input wire logic [3:0] io_o,
    input wire logic [3:0] io_oe_o,
    input wire logic [3:0] read_latency_code_o,
    input wire logic       quad_en_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    wire rd_w = io_oe_o != 4'h0;
    sequence cs_idle;
        cs_n_i [*6];
    endsequence
    sequence in_read;
        rd_w && $past(rd_w);
    endsequence
    AST_OE_LEGAL: assert property (rd_w |-> io_oe_o == 4'h2 || io_oe_o == 4'hf)
        else $error("bad enable");
    AST_OE_QUAD: assert property (io_oe_o == 4'hf |-> quad_en_o)
        else $error("quad without bit");
    AST_OE_IDLE: assert property (cs_idle |-> !rd_w)
        else $error("drive when idle");
    AST_CFG_HOLD: assert property (in_read |-> $stable({read_latency_code_o, quad_en_o}))
        else $error("config moved");
    AST_OE_WIDTH: assert property (in_read |-> io_oe_o == $past(io_oe_o))
        else $error("width moved");
    AST_IO_SCK: assert property (in_read and $changed(io_o) |-> !sck_i)
        else $error("data moved sck high");
    AST_OE_RISE: assert property ($rose(rd_w) |-> !sck_i && !cs_n_i)
        else $error("drive start");
    AST_RST_CLEAR: assert property ($rose(arst_n_i) |-> {read_latency_code_o, quad_en_o} == 5'h00)
        else $error("reset value");
endmodule // slc_spi_latency_cfg_chk

bind slc_spi_latency_cfg slc_spi_latency_cfg_chk u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .io_o(io_o), .io_oe_o(io_oe_o),
    .read_latency_code_o(read_latency_code_o), .quad_en_o(quad_en_o));

/* slc_host.sv */
module slc_host (
    // Link outputs
    output logic            sck_o,
    output logic            cs_n_o,
    output logic      [3:0] io_h_o,
    // Resolved pins
    input  wire logic [3:0] io_w_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_h_o = 4'hf;
    end
    task automatic tick(input logic b);
        #62.5 sck_o = 1'b0;
        io_h_o[0] = b;
        #62.5 sck_o = 1'b1;
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] ad, input logic ua,
                         input logic [7:0] wd, input logic wr, input int dm,
                         input logic qd, output logic [7:0] rd);
        logic [39:0] sh;
        int          n;
        sh = ua ? {op, ad, wd} : {op, wd, 24'h0};
        n = (ua ? 32 : 8) + (wr ? 8 : 0);
        cs_n_o = 1'b0;
        for (int k = 0; k < n; k++) tick(sh[39-k]);
        repeat (dm) tick(1'b1);
        for (int k = 0; k < (wr ? 0 : qd ? 2 : 8); k++) begin
            tick(1'b1);
            rd = qd ? {rd[3:0], io_w_i} : {rd[6:0], io_w_i[1]};
        end
        #62.5 sck_o = 1'b0;
        #62.5 cs_n_o = 1'b1;
        #300;
    endtask
    task automatic hwrst;
        io_h_o[3] = 1'b0;
        #100 io_h_o[3] = 1'b1;
        #300;
    endtask
endmodule // slc_host

/* tb.sv */
`include "slc_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        sck, cs_n, quad;
    logic [3:0]  io_h, io_o, io_oe, io_i, code, c;
    logic [23:0] ma, a;
    logic [7:0]  r, v, nv;
    logic [15:0] s = 16'h6253;
    int          fails = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    assign io_i = (io_oe & io_o) | (~io_oe & io_h);
    slc_spi_latency_cfg dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sck_i(sck), .cs_n_i(cs_n),
        .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe), .mem_addr_o(ma),
        .mem_rdata_i(ma[7:0] ^ 8'h5a), .read_latency_code_o(code), .quad_en_o(quad));
    slc_host h (.sck_o(sck), .cs_n_o(cs_n), .io_h_o(io_h), .io_w_i(io_i));
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [23:0] ad, input logic [7:0] d);
        h.frame(`SLC_OP_WRITE_ANY, ad, 1'b1, d, 1'b1, 0, 1'b0, r);
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int dm);
        h.frame(op, ad, op != `SLC_OP_READ_CFG1, 8'h0, 1'b0, dm, op == `SLC_OP_QUAD_READ, r);
    endtask
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        rd(`SLC_OP_READ_CFG1, 24'h0, 0);
        chk(r, `SLC_REG_RESET);
        for (int i = 0; i < 4; i++) begin
            s = nx(s);
            v = (i == 0) ? 8'hfd : s[7:0] & 8'hfd;
            if (i[0]) nv = v;
            wr(i[0] ? `SLC_ADDR_NONVOL : `SLC_ADDR_VOL, v);
            rd(`SLC_OP_READ_ANY, `SLC_ADDR_NONVOL, 0);
            chk(r, v & `SLC_WRITE_MASK);
            rd(`SLC_OP_READ_ANY, `SLC_ADDR_VOL, 0);
            chk(r, v & `SLC_WRITE_MASK);
            rd(`SLC_OP_READ_CFG1, 24'h0, 0);
            chk(r, v & `SLC_WRITE_MASK);
            chk({code, 2'b00, quad, 1'b0}, v & `SLC_WRITE_MASK);
        end
        wr(24'h000003, 8'hf0);
        rd(`SLC_OP_READ_CFG1, 24'h0, 0);
        chk(r, nv & `SLC_WRITE_MASK);
        rd(`SLC_OP_READ_ANY, 24'h000001, 0);
        chk(r, 8'h00);
        wr(`SLC_ADDR_VOL, ~nv & 8'hf0);
        h.hwrst();
        rd(`SLC_OP_READ_CFG1, 24'h0, 0);
        chk(r, nv & `SLC_WRITE_MASK);
        rd(`SLC_OP_QUAD_READ, 24'h000010, 0);
        chk(r, 8'hff);
        for (int j = 0; j < 6; j++) begin
            s = nx(s);
            c = (j < 2) ? 4'h0 : (j < 4) ? 4'h6 : (j == 4) ? 4'hf : s[11:8];
            a = {s[7:0], s};
            wr(`SLC_ADDR_VOL, {c, 2'b00, j[0], 1'b0});
            rd(j[0] ? `SLC_OP_QUAD_READ : `SLC_OP_MEM_READ, a, c);
            chk(r, a[7:0] ^ 8'h5a);
        end
        end_sim();
    end
endmodule // tb
